// ### src/cmac_dev.sv
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
module cmac_dev #(
  parameter int unsigned WAYS    = cmac_pkg::WAYS_DEF,    // Ways per entry
  parameter int unsigned ENTRIES = cmac_pkg::ENTRIES_DEF  // Entries per way
) (
  input  wire logic         clk,        // 100 MHz clock
  input  wire logic         rst,        // Async reset, active high
  cmac_if.dev               lnk,        // CPU access port
  output logic              wb_valid_q, // Write-back line pending
  output logic [31:0]       wb_addr_q,  // Physical line address
  output logic [127:0]      wb_line_q,  // Longwords 3..0
  input  wire logic         wb_ready,   // Memory takes the line
  input  wire logic         lk_valid,   // Lookup request
  input  wire logic [31:0]  lk_addr,    // Physical lookup address
  output logic              lk_hit_q,   // Lookup hit
  output logic [1:0]        lk_way_q    // Hitting way
);
  localparam int unsigned LINES = WAYS * ENTRIES;
  localparam int unsigned LN_W  = cmac_pkg::WAY_W + cmac_pkg::IDX_W;
  localparam int unsigned WD_W  = LN_W + cmac_pkg::LW_W;

  logic [cmac_pkg::TAG_W-1:0]  tag_q   [LINES];
  logic [cmac_pkg::HIST_W-1:0] hist_q  [ENTRIES];
  logic                        dirty_q [LINES];
  logic                        valid_q [LINES];
  logic [31:0]                 data_q  [LINES*cmac_pkg::LINE_WORDS];

  logic        ack_q;
  logic        err_q;
  logic [31:0] rdata_q;

  function automatic logic [cmac_pkg::IDX_W-1:0] idx_of(input logic [31:0] a);
    return a[cmac_pkg::IDX_LSB +: cmac_pkg::IDX_W];
  endfunction : idx_of

  function automatic logic [LN_W-1:0] line_of(input logic [1:0] w, input logic [cmac_pkg::IDX_W-1:0] i);
    return {w, i};
  endfunction : line_of

  function automatic logic [WD_W-1:0] word_of(input logic [LN_W-1:0] ln, input logic [1:0] l);
    return {ln, l};
  endfunction : word_of

  logic [7:0]                 area;
  logic                       is_tag;
  logic                       is_data;
  logic [cmac_pkg::IDX_W-1:0] idx;
  logic [1:0]                 way;
  logic [1:0]                 lw;
  logic                       assoc;
  logic [LN_W-1:0]            ln;
  logic [cmac_pkg::TAG_W-1:0] wtag;
  logic                       hit_any;
  logic [1:0]                 hit_way;
  logic [LN_W-1:0]            hit_ln;
  logic [LN_W-1:0]            wb_ln;
  logic                       take;
  logic                       bad;
  logic                       tag_wr;
  logic                       need_wb;
  logic                       ready_op;
  logic                       do_op;

  always_comb begin
    area    = lnk.addr[31:cmac_pkg::AREA_LSB];
    is_tag  = area == cmac_pkg::AREA_TAG;
    is_data = area == cmac_pkg::AREA_DATA;
    idx     = idx_of(lnk.addr);
    way     = lnk.addr[cmac_pkg::WAY_LSB +: cmac_pkg::WAY_W];
    lw      = lnk.addr[cmac_pkg::LW_LSB +: cmac_pkg::LW_W];
    assoc   = lnk.addr[cmac_pkg::ASSOC_BIT];
    ln      = line_of(way, idx);
    wtag    = lnk.wdata[cmac_pkg::TAG_LSB +: cmac_pkg::TAG_W];
  end

  // Associative compare across every way of the indexed entry
  always_comb begin
    hit_any = 1'b0;
    hit_way = 2'h0;
    for (int w = WAYS - 1; w >= 0; w--) begin
      if (tag_q[line_of(w[1:0], idx)] == wtag) begin
        hit_any = 1'b1;
        hit_way = w[1:0];
      end
    end
    hit_ln = line_of(hit_way, idx);
  end

  // Unprivileged, unmapped or misaligned requests are refused, not executed
  assign take    = lnk.req && !ack_q;
  assign bad     = !lnk.priv || !(is_tag || is_data) || (lnk.addr[1:0] != 2'h0);
  assign tag_wr  = take && !bad && lnk.we && is_tag;
  always_comb begin
    need_wb = 1'b0;
    wb_ln   = ln;
    if (tag_wr && !assoc) begin
      need_wb = dirty_q[ln] && valid_q[ln];
    end else if (tag_wr && assoc) begin
      need_wb = hit_any && dirty_q[hit_ln];
      wb_ln   = hit_ln;
    end
  end
  // Stall only while an occupied buffer cannot take another line
  assign ready_op = !need_wb || !wb_valid_q || wb_ready;
  assign do_op    = take && !bad && ready_op;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_q   <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= cmac_pkg::RESET_WORD;
    end else begin
      ack_q <= take && (bad || ready_op);
      err_q <= take && bad;
      if (do_op && !lnk.we && is_tag) begin
        rdata_q <= '0;
        rdata_q[cmac_pkg::TAG_LSB +: cmac_pkg::TAG_W]   <= tag_q[ln];
        rdata_q[cmac_pkg::HIST_LSB +: cmac_pkg::HIST_W] <= hist_q[idx];
        rdata_q[cmac_pkg::DIRTY_BIT] <= dirty_q[ln];
        rdata_q[cmac_pkg::VALID_BIT] <= valid_q[ln];
      end else if (do_op && !lnk.we && is_data) begin
        rdata_q <= data_q[word_of(ln, lw)];
      end else begin
        rdata_q <= cmac_pkg::RESET_WORD;
      end
    end
  end

  // Flags and history; data accesses never reach here
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < LINES; i++) begin
        dirty_q[i] <= 1'b0;
        valid_q[i] <= 1'b0;
      end
      for (int i = 0; i < ENTRIES; i++)
        hist_q[i] <= '0;
    end else if (do_op && tag_wr) begin
      if (!assoc) begin
        dirty_q[ln] <= lnk.wdata[cmac_pkg::DIRTY_BIT];
        valid_q[ln] <= lnk.wdata[cmac_pkg::VALID_BIT];
        hist_q[idx] <= lnk.wdata[cmac_pkg::HIST_LSB +: cmac_pkg::HIST_W];
      end else if (hit_any) begin
        dirty_q[hit_ln] <= lnk.wdata[cmac_pkg::DIRTY_BIT];
        valid_q[hit_ln] <= lnk.wdata[cmac_pkg::VALID_BIT];
      end
    end
  end

  // Tags are data, so they carry no reset
  always_ff @(posedge clk) begin
    if (do_op && tag_wr && !assoc)
      tag_q[ln] <= wtag;
  end

  always_ff @(posedge clk) begin
    if (do_op && lnk.we && is_data)
      data_q[word_of(ln, lw)] <= lnk.wdata;
  end

  // Old line is captured in the same edge as the tag entry update (tag and flags, or flags alone when associative)
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_valid_q <= 1'b0;
      wb_addr_q  <= cmac_pkg::RESET_WORD;
      wb_line_q  <= '0;
    end else if (do_op && need_wb) begin
      wb_valid_q <= 1'b1;
      wb_addr_q  <= {tag_q[wb_ln], idx[cmac_pkg::TAG_LSB-cmac_pkg::IDX_LSB-1:0],
                     cmac_pkg::LINE_OFS_W'(0)};
      for (int l = 0; l < cmac_pkg::LINE_WORDS; l++)
        wb_line_q[32*l +: 32] <= data_q[word_of(wb_ln, l[1:0])];
    end else if (wb_ready) begin
      wb_valid_q <= 1'b0;
    end
  end

  // Normal lookup hit check, one cycle latency
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lk_hit_q <= 1'b0;
      lk_way_q <= 2'h0;
    end else begin
      lk_hit_q <= 1'b0;
      lk_way_q <= 2'h0;
      if (lk_valid) begin
        for (int w = WAYS - 1; w >= 0; w--) begin
          if (valid_q[line_of(w[1:0], idx_of(lk_addr))] &&
              tag_q[line_of(w[1:0], idx_of(lk_addr))] == lk_addr[31:cmac_pkg::TAG_LSB]) begin
            lk_hit_q <= 1'b1;
            lk_way_q <= w[1:0];
          end
        end
      end
    end
  end

  assign lnk.ack   = ack_q;
  assign lnk.err   = err_q;
  assign lnk.rdata = rdata_q;
endmodule : cmac_dev

// ### src/cmac_pkg.sv
package cmac_pkg;
  // Region select in address bits 31-24
  localparam int unsigned AREA_LSB  = 24;
  localparam logic [7:0]  AREA_TAG  = 8'hF0;
  localparam logic [7:0]  AREA_DATA = 8'hF1;
  // Address field layout
  localparam int unsigned IDX_LSB   = 4;
  localparam int unsigned IDX_W     = 8;
  localparam int unsigned WAY_LSB   = 12;
  localparam int unsigned WAY_W     = 2;
  localparam int unsigned ASSOC_BIT = 3;
  localparam int unsigned LW_LSB    = 2;
  localparam int unsigned LW_W      = 2;
  // Tag-array data word layout
  localparam int unsigned TAG_LSB   = 10;
  localparam int unsigned TAG_W     = 22;
  localparam int unsigned HIST_LSB  = 4;
  localparam int unsigned HIST_W    = 6;
  localparam int unsigned DIRTY_BIT = 1;
  localparam int unsigned VALID_BIT = 0;
  localparam int unsigned TAG_TOP_W = 3;
  // Line geometry
  localparam int unsigned LINE_WORDS = 4;
  localparam int unsigned LINE_W     = 128;
  localparam int unsigned LINE_OFS_W = 4;
  // Default geometry
  localparam int unsigned WAYS_DEF    = 4;
  localparam int unsigned ENTRIES_DEF = 256;
  // Controller registers, byte offsets
  localparam logic [7:0] REG_CMD_ADDR = 8'h00;
  localparam logic [7:0] REG_CMD_DATA = 8'h04;
  localparam logic [7:0] REG_CMD_GO   = 8'h08;
  localparam logic [7:0] REG_STATUS   = 8'h0C;
  localparam logic [7:0] REG_RESULT   = 8'h10;
  // Field positions in controller registers
  localparam int unsigned GO_STORE_BIT = 0;
  localparam int unsigned GO_USER_BIT  = 1;
  localparam int unsigned ST_BUSY_BIT  = 0;
  localparam int unsigned ST_ERR_BIT   = 1;
  localparam logic [31:0] RESET_WORD   = 32'h0000_0000;
endpackage : cmac_pkg

// ### src/cmac_if.sv
`timescale 1ns/10ps
interface cmac_if;
  logic        req;    // Access request, held until ack
  logic        we;     // 1 store, 0 load
  logic        priv;   // Privileged access
  logic [31:0] addr;   // Virtual address
  logic [31:0] wdata;  // Store data
  logic [31:0] rdata;  // Load data, valid with ack
  logic        ack;    // One-cycle completion pulse
  logic        err;    // Refused access, valid with ack

  modport dev (input req, we, priv, addr, wdata, output rdata, ack, err);
  modport cpu (output req, we, priv, addr, wdata, input rdata, ack, err);
endinterface : cmac_if

// ### src/cmac_cpu.sv
`timescale 1ns/10ps
module cmac_cpu (
  input  wire logic        clk,       // 100 MHz clock
  input  wire logic        rst,       // Async reset, active high
  cmac_if.cpu              lnk,       // Link to cache array port
  input  wire logic [7:0]  reg_addr,  // Register byte address
  input  wire logic [31:0] reg_wdata, // Register write data
  input  wire logic        reg_wr,    // Write strobe
  input  wire logic        reg_rd,    // Read strobe
  output logic      [31:0] reg_rdata  // Read data, cycle after strobe
);
  logic [31:0] cmd_addr_q;
  logic [31:0] cmd_data_q;
  logic [31:0] result_q;
  logic        busy_q;
  logic        err_q;
  logic        req_q;
  logic        we_q;
  logic        priv_q;
  logic [31:0] addr_q;
  logic [31:0] wdata_q;
  logic [31:0] rdata_q;
  logic        go;
  logic        go_store;
  logic        tag_area;
  logic [31:0] data_fix;

  assign go       = reg_wr && (reg_addr == cmac_pkg::REG_CMD_GO) && !busy_q;
  assign go_store = reg_wdata[cmac_pkg::GO_STORE_BIT];
  assign tag_area = cmd_addr_q[31:cmac_pkg::AREA_LSB] == cmac_pkg::AREA_TAG;

  // Sanitise tag-area store values before they reach the arrays; data-area values pass unchanged
  always_comb begin
    data_fix = cmd_data_q;
    if (tag_area) begin
      data_fix[31 -: cmac_pkg::TAG_TOP_W] = '0;
      if (!cmd_data_q[cmac_pkg::VALID_BIT])
        data_fix[cmac_pkg::DIRTY_BIT] = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_addr_q <= cmac_pkg::RESET_WORD;
      cmd_data_q <= cmac_pkg::RESET_WORD;
    end else if (reg_wr && !busy_q) begin
      if (reg_addr == cmac_pkg::REG_CMD_ADDR)
        cmd_addr_q <= reg_wdata;
      if (reg_addr == cmac_pkg::REG_CMD_DATA)
        cmd_data_q <= reg_wdata;
    end
  end

  // One longword access at a time, held until acknowledged
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_q   <= 1'b0;
      we_q    <= 1'b0;
      priv_q  <= 1'b0;
      addr_q  <= cmac_pkg::RESET_WORD;
      wdata_q <= cmac_pkg::RESET_WORD;
      busy_q  <= 1'b0;
    end else if (go) begin
      req_q   <= 1'b1;
      we_q    <= go_store;
      priv_q  <= !reg_wdata[cmac_pkg::GO_USER_BIT];
      addr_q  <= {cmd_addr_q[31:2], 2'h0};
      wdata_q <= data_fix;
      busy_q  <= 1'b1;
    end else if (req_q && lnk.ack) begin
      req_q  <= 1'b0;
      busy_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result_q <= cmac_pkg::RESET_WORD;
      err_q    <= 1'b0;
    end else if (req_q && lnk.ack) begin
      result_q <= lnk.rdata;
      err_q    <= lnk.err;
    end else if (go) begin
      err_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= cmac_pkg::RESET_WORD;
    end else if (reg_rd) begin
      unique case (reg_addr)
        cmac_pkg::REG_CMD_ADDR: rdata_q <= cmd_addr_q;
        cmac_pkg::REG_CMD_DATA: rdata_q <= cmd_data_q;
        cmac_pkg::REG_STATUS:   rdata_q <= {30'h0, err_q, busy_q};
        cmac_pkg::REG_RESULT:   rdata_q <= result_q;
        default:                rdata_q <= cmac_pkg::RESET_WORD;
      endcase
    end else begin
      rdata_q <= cmac_pkg::RESET_WORD;
    end
  end

  assign lnk.req   = req_q;
  assign lnk.we    = we_q;
  assign lnk.priv  = priv_q;
  assign lnk.addr  = addr_q;
  assign lnk.wdata = wdata_q;
  assign reg_rdata = rdata_q;
endmodule : cmac_cpu

// ### verif/cmac_asserts.sv
`timescale 1ns/10ps
module cmac_asserts (
  input wire logic        clk,   // Clock
  input wire logic        rst,   // Async reset
  input wire logic        req,   // Request
  input wire logic        we,    // Store
  input wire logic        priv,  // Privileged
  input wire logic [31:0] addr,  // Address
  input wire logic [31:0] wdata, // Store data
  input wire logic [31:0] rdata, // Load data
  input wire logic        ack,   // Completion
  input wire logic        err    // Refused
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_bad;
    ack && (!priv || !(addr[31:24] inside {8'hF0, 8'hF1}) || addr[1:0] != 2'h0);
  endsequence
  sequence s_ok;
    ack && priv && (addr[31:24] inside {8'hF0, 8'hF1}) && addr[1:0] == 2'h0;
  endsequence
  sequence s_tagrd;
    ack && !err && !we && addr[31:24] == cmac_pkg::AREA_TAG;
  endsequence
  a_ack_pulse: assert property (ack |=> !ack) else $error("ack held too long");
  a_ack_cause: assert property ($rose(ack) |-> $past(req)) else $error("ack without request");
  a_ack_req: assert property (ack |-> req) else $error("ack after request dropped");
  a_refuse_bad: assert property (s_bad |-> err) else $error("bad access not refused");
  a_accept_good: assert property (s_ok |-> !err) else $error("good access refused");
  a_idle_rdata: assert property (!ack |-> rdata == 32'h0) else $error("load data outside ack");
  a_err_quiet: assert property (ack && err |-> rdata == 32'h0) else $error("refused access returned data");
  a_tag_pad: assert property (s_tagrd |-> rdata[3:2] == 2'h0) else $error("tag word pad bits set");
  a_req_hold: assert property (req && !ack |=> req && $stable(addr) && $stable(wdata) && $stable(we))
    else $error("request changed before ack");
  a_ack_bound: assert property ($rose(req) |-> ##[1:200] ack) else $error("request never answered");
endmodule : cmac_asserts

// ### verif/cache_array_mapped_access_test.sv
`timescale 1ns/10ps
module cache_array_mapped_access_test;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic [7:0]   reg_addr = 8'h00;
  logic [31:0]  reg_wdata = 32'h0;
  logic         reg_wr = 1'b0;
  logic         reg_rd = 1'b0;
  logic         wb_ready = 1'b0;
  logic         lk_valid = 1'b0;
  logic [31:0]  lk_addr = 32'h0;
  logic [31:0]  reg_rdata, wb_addr_q, res;
  logic [127:0] wb_line_q;
  logic         wb_valid_q, lk_hit_q, er;
  logic [1:0]   lk_way_q;
  int           bad_count = 0;
  int           num_checks = 0;
  cmac_if lnk ();
  cmac_cpu u_cmac_cpu (.clk(clk), .rst(rst), .lnk(lnk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  cmac_dev u_cmac_dev (.clk(clk), .rst(rst), .lnk(lnk), .wb_valid_q(wb_valid_q), .wb_addr_q(wb_addr_q),
    .wb_line_q(wb_line_q), .wb_ready(wb_ready), .lk_valid(lk_valid), .lk_addr(lk_addr),
    .lk_hit_q(lk_hit_q), .lk_way_q(lk_way_q));
  cmac_asserts u_cmac_asserts (.clk(clk), .rst(rst), .req(lnk.req), .we(lnk.we), .priv(lnk.priv),
    .addr(lnk.addr), .wdata(lnk.wdata), .rdata(lnk.rdata), .ack(lnk.ack), .err(lnk.err));
  always #5 clk = ~clk;

  task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  task automatic rw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : rw
  task automatic rr(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rr
  // Full access through the controller; result and error land in res and er
  task automatic op(input logic [31:0] a, input logic [31:0] d, input logic [1:0] go);
    logic [31:0] s;
    rw(cmac_pkg::REG_CMD_ADDR, a);
    rw(cmac_pkg::REG_CMD_DATA, d);
    rw(cmac_pkg::REG_CMD_GO, {30'h0, go});
    s = 32'h1;
    for (int i = 0; i < 20 && s[0] !== 1'b0; i++) rr(cmac_pkg::REG_STATUS, s);
    check("busy", s[0], 1'b0);
    er = s[1];
    rr(cmac_pkg::REG_RESULT, res);
  endtask : op
  task automatic look(input logic [31:0] a, input logic hit, input logic [1:0] wy);
    @(posedge clk);
    lk_valid <= 1'b1;
    lk_addr <= a;
    @(posedge clk);
    lk_valid <= 1'b0;
    #1 check("hit", {lk_hit_q, lk_way_q}, {hit, wy});
  endtask : look
  task automatic drain();
    @(posedge clk);
    wb_ready <= 1'b1;
    repeat (2) @(posedge clk);
    wb_ready <= 1'b0;
    #1 check("wb drained", wb_valid_q, 1'b0);
  endtask : drain
  function automatic logic [31:0] ta(input logic [1:0] w, input logic [7:0] i, input logic as);
    return {8'hF0, 10'h0, w, i, as, 3'h0};
  endfunction : ta
  function automatic logic [31:0] da(input logic [1:0] w, input logic [7:0] i, input logic [1:0] l);
    return {8'hF1, 10'h0, w, i, l, 2'h0};
  endfunction : da
  function automatic logic [31:0] tw(input logic [21:0] t, input logic [5:0] h, input logic u, input logic v);
    return {t, h, 2'h0, u, v};
  endfunction : tw

  initial begin
    #100000;
    bad_count++;
    summarize();
  end
  initial begin
    logic [31:0] d [4];
    logic [21:0] t;
    logic [5:0]  h;
    logic [1:0]  w;
    logic [7:0]  ix;
    void'($urandom(32'hB223));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      w = $urandom;
      ix = $urandom;
      for (int l = 0; l < 4; l++) begin
        d[l] = $urandom;
        op(da(w, ix, l[1:0]), d[l], 2'b01);
      end
      for (int l = 3; l >= 0; l--) begin
        op(da(w, ix, l[1:0]), 32'h0, 2'b00);
        check("data word", res, d[l]);
      end
    end
    // Top tag bits forced high: the controller must clear them
    w = $urandom;
    h = $urandom;
    t = $urandom;
    t[21:19] = 3'h7;
    t[1:0] = 2'h0;
    op(ta(w, 8'h3C, 1'b0), tw(t, h, 1'b0, 1'b1) | 32'hC, 2'b01);
    t[21:19] = 3'h0;
    op(da(w, 8'h3C, 2'h1), 32'h5A5A_1234, 2'b01);
    op(ta(w, 8'h3C, 1'b1), 32'h0, 2'b00);
    check("tag word", res, tw(t, h, 1'b0, 1'b1));
    check("err", er, 1'b0);
    look({t, 6'h3C, 4'h0}, 1'b1, w);
    look({t ^ 22'h100, 6'h3C, 4'h0}, 1'b0, 2'h0);
    for (int l = 0; l < 4; l++) begin
      d[l] = $urandom;
      op(da(w, 8'h3C, l[1:0]), d[l], 2'b01);
    end
    op(ta(w, 8'h3C, 1'b0), tw(t, h, 1'b1, 1'b1), 2'b01);
    check("wb early", wb_valid_q, 1'b0);
    op(ta(w, 8'h3C, 1'b0), tw(t ^ 22'h40, h, 1'b0, 1'b1), 2'b01);
    check("wb line", {wb_valid_q, wb_addr_q, wb_line_q}, {1'b1, t, 6'h3C, 4'h0, d[3], d[2], d[1], d[0]});
    drain();
    // Refusals must leave the entry alone
    op(ta(w, 8'h3C, 1'b0), 32'h0, 2'b11);
    check("user err", {er, res}, {1'b1, 32'h0});
    op(32'hF200_0000, 32'h0, 2'b00);
    check("area err", {er, res}, {1'b1, 32'h0});
    op(ta(w, 8'h3C, 1'b0), 32'h0, 2'b00);
    check("tag kept", res, tw(t ^ 22'h40, h, 1'b0, 1'b1));
    // Invalidate by compare: a matching tag without valid must miss
    op(ta(2'h0, 8'h3C, 1'b1), tw(t ^ 22'h40, h, 1'b0, 1'b0), 2'b01);
    look({t ^ 22'h40, 6'h3C, 4'h0}, 1'b0, 2'h0);
    rr(8'h20, res);
    check("unmapped", res, 32'h0);
    // Bit 2 cleared too, else the miss tag below could equal way 0
    t[2:0] = 3'h0;
    for (int k = 0; k < 4; k++) op(ta(k[1:0], 8'h41, 1'b0), tw(t | 22'(k), h, k == 2, 1'b1), 2'b01);
    op(ta(2'h0, 8'h41, 1'b1), tw(t | 22'h4, h, 1'b0, 1'b0), 2'b01);
    check("miss wb", wb_valid_q, 1'b0);
    op(ta(2'h2, 8'h41, 1'b0), 32'h0, 2'b00);
    check("miss keep", res, tw(t | 22'h2, h, 1'b1, 1'b1));
    op(ta(2'h1, 8'h41, 1'b1), tw(t | 22'h2, ~h, 1'b0, 1'b0), 2'b01);
    check("hit wb", {wb_valid_q, wb_addr_q}, {1'b1, t | 22'h2, 6'h01, 4'h0});
    for (int k = 0; k < 4; k++) begin
      op(ta(k[1:0], 8'h41, 1'b0), 32'h0, 2'b00);
      check("assoc tag", res, tw(t | 22'(k), h, 1'b0, k != 2));
    end
    look({t | 22'h1, 6'h01, 4'h0}, 1'b1, 2'h1);
    op(ta(2'h0, 8'h41, 1'b0), tw(t, h, 1'b1, 1'b0), 2'b01);
    op(ta(2'h0, 8'h41, 1'b0), 32'h0, 2'b00);
    check("valid clears dirty", res, tw(t, h, 1'b0, 1'b0));
    op(da(w, 8'h3C, 2'h1) | 32'h3, 32'h0, 2'b00);
    check("aligned load", {er, res}, {1'b0, d[1]});
    rr(cmac_pkg::REG_CMD_ADDR, res);
    check("raw address", res, da(w, 8'h3C, 2'h1) | 32'h3);
    drain();
    summarize();
  end
endmodule : cache_array_mapped_access_test
